/* File: monitor_pkg.sv */
// constants and types shared by the alarm flag and channel select logic
package monitor_pkg;

  localparam int REG_WIDTH = 16;
  localparam int ADDR_WIDTH = 7;
  localparam int TEMP_WIDTH = 12;
  localparam int ADC_CODE_WIDTH = 12;

  localparam logic [ADDR_WIDTH-1:0] ADDR_ALARM_STATUS = 7'h4f;
  localparam logic [ADDR_WIDTH-1:0] ADDR_CHANNEL_SELECT_ZERO = 7'h50;

  localparam logic [REG_WIDTH-1:0] ALARM_STATUS_RESET = 16'h0000;
  localparam logic [REG_WIDTH-1:0] CHANNEL_SELECT_RESET = 16'h0000;

  // status field positions
  localparam int POS_REMOTE_A_OVER = 7;
  localparam int POS_REMOTE_B_UNDER = 6;
  localparam int POS_REMOTE_B_OVER = 5;
  localparam int POS_REMOTE_A_BROKEN = 4;
  localparam int POS_REMOTE_B_BROKEN = 3;
  localparam int POS_DIE_OVERHEAT = 2;

  // channel select field positions
  localparam int POS_SELECT_RESERVED = 15;
  localparam int POS_SE0 = 14;
  localparam int POS_SE1 = 13;
  localparam int POS_FIRST_PAIR_DIFF = 12;
  localparam int POS_SE2 = 11;
  localparam int POS_SE3 = 10;
  localparam int POS_SECOND_PAIR_DIFF = 9;
  localparam int POS_SE4 = 8;
  localparam int NUM_PLAIN_SE = 9;

  // temperatures in steps of 1/8 degree C, two's complement
  localparam int TEMP_STEPS_PER_DEGC = 8;
  localparam int DIE_TRIP_DEGC = 150;
  localparam int DIE_HYST_DEGC = 8;
  localparam logic signed [TEMP_WIDTH-1:0] DIE_TRIP_CODE = 12'(DIE_TRIP_DEGC * TEMP_STEPS_PER_DEGC);
  localparam logic signed [TEMP_WIDTH-1:0] DIE_CLEAR_CODE =
    12'((DIE_TRIP_DEGC - DIE_HYST_DEGC) * TEMP_STEPS_PER_DEGC);

  // conversion slots in visiting order, slot 0 first
  localparam int NUM_SLOTS = 18;
  localparam int SLOT_FIRST_DIFF = 2;
  localparam int SLOT_SECOND_DIFF = 5;
  localparam int SLOT_PLAIN_SE = 6;
  localparam int SLOT_HIGH = 15;
  localparam logic [NUM_SLOTS-1:0][3:0] SLOT_CHANNEL = {
    4'hf, 4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7,
    4'h6, 4'h5, 4'h4, 4'h2, 4'h3, 4'h2, 4'h0, 4'h1, 4'h0};
  localparam logic [NUM_SLOTS-1:0] SLOT_DIFF = 18'h00024;

  typedef struct packed {
    logic a_over;
    logic b_under;
    logic b_over;
    logic a_broken;
    logic b_broken;
    logic die;
  } alarm_bits_s;

  typedef struct packed {
    logic       diff;
    logic [3:0] channel;
  } conv_req_s;

  typedef struct packed {
    logic [3:0]           channel;
    logic [REG_WIDTH-1:0] data;
  } result_write_s;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT, SEQ_STORE} seq_state_e;

endpackage

/* File: channel_sequencer.sv */
// walks the selected conversion slots in order and formats each result
`timescale 1ns/1ps
`default_nettype none
module channel_sequencer (
  input  wire logic                                 clock,
  input  wire logic                                 reset,
  input  wire logic                                 start,
  input  wire logic [monitor_pkg::NUM_SLOTS-1:0]     slot_select,
  output var  logic                                 busy,
  output var  logic                                 conv_valid,
  output var  monitor_pkg::conv_req_s               conv,
  input  wire logic                                 conv_done,
  input  wire logic [monitor_pkg::ADC_CODE_WIDTH-1:0] conv_code,
  output var  logic                                 result_valid,
  output var  monitor_pkg::result_write_s           result
);
  import monitor_pkg::*;

  typedef struct packed {
    seq_state_e           state;
    logic [NUM_SLOTS-1:0] pending;
    logic [4:0]           slot;
    logic                 busy;
    logic                 conv_valid;
    conv_req_s            conv;
    logic                 result_valid;
    result_write_s        result;
  } seq_s;

  seq_s state;
  seq_s next_state;

  // lowest pending slot index
  function automatic logic [4:0] first_pending(input logic [NUM_SLOTS-1:0] mask);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (mask[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  always_comb begin
    next_state = state;
    next_state.result_valid = 1'b0;
    case (state.state)
      SEQ_IDLE: begin
        next_state.busy = 1'b0;
        // selection is snapshotted at start; later writes wait for the next pass
        if (start && (|slot_select)) begin
          next_state.pending = slot_select;
          next_state.slot = first_pending(slot_select);
          next_state.busy = 1'b1;
          next_state.state = SEQ_ISSUE;
        end
      end
      SEQ_ISSUE: begin
        next_state.conv.channel = SLOT_CHANNEL[state.slot];
        next_state.conv.diff = SLOT_DIFF[state.slot];
        next_state.conv_valid = 1'b1;
        next_state.state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (conv_done) begin
          next_state.conv_valid = 1'b0;
          next_state.result.channel = state.conv.channel;
          if (state.conv.diff) begin
            next_state.result.data = {{(REG_WIDTH-ADC_CODE_WIDTH){conv_code[ADC_CODE_WIDTH-1]}}, conv_code};
          end else begin
            next_state.result.data = {{(REG_WIDTH-ADC_CODE_WIDTH){1'b0}}, conv_code};
          end
          next_state.result_valid = 1'b1;
          next_state.pending[state.slot] = 1'b0;
          next_state.state = SEQ_STORE;
        end
      end
      SEQ_STORE: begin
        // cleared slots are never visited
        if (|state.pending) begin
          next_state.slot = first_pending(state.pending);
          next_state.state = SEQ_ISSUE;
        end else begin
          next_state.busy = 1'b0;
          next_state.state = SEQ_IDLE;
        end
      end
      default: begin
        next_state.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign busy = state.busy;
  assign conv_valid = state.conv_valid;
  assign conv = state.conv;
  assign result_valid = state.result_valid;
  assign result = state.result;

endmodule
`default_nettype wire

/* File: alarm_flags_and_adc_channel_select.sv */
// alarm status flags and first adc channel select register with its sequencer
//
// Summary of operation
// - remote A over high threshold sets bit 7
// - remote B under low threshold sets bit 6
// - remote B over high threshold sets bit 5
// - remote A open or short sets bit 4
// - remote B open or short sets bit 3
// - die at or above trip sets bit 2
// - die flag zero while on-chip sensor off
// - die alarm clears only hysteresis below trip
// - visit selected channels from bit 14 down
// - bit 15 reads zero; selects reset to zero
// - single-ended results stored straight binary
// - bit 12 converts ch0 minus ch1, signed
// - bit 9 converts ch2 minus ch3, signed
// - ch0/ch1 singles override the first pair
// - ch2/ch3 singles override the second pair
// - bits 8..0 select channels 4 to 12
// - latched flags clear after condition gone and read
// - flags always set; alarm pin gated by enables
// - sequence continues with channels 13 to 15
`timescale 1ns/1ps
`default_nettype none
module alarm_flags_and_adc_channel_select (
  // clock and reset
  input  wire logic                                     CLOCK,
  input  wire logic                                     RESET,
  // register access port
  input  wire logic [monitor_pkg::ADDR_WIDTH-1:0]       REG_ADDRESS,
  input  wire logic                                     REG_WRITE,
  input  wire logic                                     REG_READ,
  input  wire logic [monitor_pkg::REG_WIDTH-1:0]        REG_WRITE_DATA,
  output var  logic [monitor_pkg::REG_WIDTH-1:0]        REG_READ_DATA,
  output var  logic                                     REG_READ_VALID,
  // temperature measurements and limits
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] REMOTE_A_TEMP,
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] REMOTE_A_HIGH_LIMIT,
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] REMOTE_B_TEMP,
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] REMOTE_B_LOW_LIMIT,
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] REMOTE_B_HIGH_LIMIT,
  input  wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] DIE_TEMP,
  input  wire logic                                     REMOTE_A_BROKEN,
  input  wire logic                                     REMOTE_B_BROKEN,
  // configuration
  input  wire logic                                     REMOTE_A_ENABLE,
  input  wire logic                                     REMOTE_B_ENABLE,
  input  wire logic                                     ON_CHIP_TEMP_SENSOR_ENABLE,
  input  wire logic                                     FLAG_HOLD_DISABLE,
  input  wire monitor_pkg::alarm_bits_s                 ALARM_ENABLE,
  input  wire logic                                     ALARM_OUTPUT_ENABLE,
  // alarm indications
  output var  logic                                     ALARM_OUT,
  output var  logic                                     ALARM_OE_N,
  output var  logic                                     THERM_ALARM,
  // conversion sequencer
  input  wire logic                                     CONV_START,
  input  wire logic [2:0]                               HIGH_CHANNEL_SELECT,
  output var  logic                                     SEQ_BUSY,
  output var  logic                                     CONV_VALID,
  output var  monitor_pkg::conv_req_s                   CONV_REQUEST,
  input  wire logic                                     CONV_DONE,
  input  wire logic [monitor_pkg::ADC_CODE_WIDTH-1:0]   CONV_CODE,
  output var  logic                                     RESULT_VALID,
  output var  monitor_pkg::result_write_s               RESULT
);
  import monitor_pkg::*;

  typedef struct packed {
    logic [POS_SE0:0]     select;
    alarm_bits_s          flags;
    logic                 die_hot;
    logic [REG_WIDTH-1:0] read_data;
    logic                 read_valid;
    logic                 alarm_oe_n;
    logic                 alarm_out;
    logic                 therm_alarm;
  } regs_s;

  regs_s                state;
  regs_s                next_state;
  alarm_bits_s          cond;
  logic                 status_read;
  logic [REG_WIDTH-1:0] select_word;
  logic [REG_WIDTH-1:0] status_word;
  logic [NUM_SLOTS-1:0] slot_select;

  assign status_read = REG_READ && (REG_ADDRESS == ADDR_ALARM_STATUS);
  assign select_word = {1'b0, state.select};

  always_comb begin
    status_word = ALARM_STATUS_RESET;
    status_word[POS_REMOTE_A_OVER] = state.flags.a_over;
    status_word[POS_REMOTE_B_UNDER] = state.flags.b_under;
    status_word[POS_REMOTE_B_OVER] = state.flags.b_over;
    status_word[POS_REMOTE_A_BROKEN] = state.flags.a_broken;
    status_word[POS_REMOTE_B_BROKEN] = state.flags.b_broken;
    status_word[POS_DIE_OVERHEAT] = state.flags.die;
  end

  // effective slot selection; a single-ended select in a pair disables the diff
  assign slot_select[0] = state.select[POS_SE0];
  assign slot_select[1] = state.select[POS_SE1];
  assign slot_select[SLOT_FIRST_DIFF] = state.select[POS_FIRST_PAIR_DIFF]
                                        && !state.select[POS_SE0] && !state.select[POS_SE1];
  assign slot_select[3] = state.select[POS_SE2];
  assign slot_select[4] = state.select[POS_SE3];
  assign slot_select[SLOT_SECOND_DIFF] = state.select[POS_SECOND_PAIR_DIFF]
                                         && !state.select[POS_SE2] && !state.select[POS_SE3];
  for (genvar g = 0; g < NUM_PLAIN_SE; g++) begin : g_plain_se
    assign slot_select[SLOT_PLAIN_SE+g] = state.select[POS_SE4-g];
  end
  for (genvar h = 0; h < 3; h++) begin : g_high
    assign slot_select[SLOT_HIGH+h] = HIGH_CHANNEL_SELECT[2-h];
  end

  always_comb begin
    next_state = state;
    // raw conditions, each checked only while its sensor is enabled
    cond.a_over = REMOTE_A_ENABLE && (REMOTE_A_TEMP > REMOTE_A_HIGH_LIMIT);
    cond.b_under = REMOTE_B_ENABLE && (REMOTE_B_TEMP < REMOTE_B_LOW_LIMIT);
    cond.b_over = REMOTE_B_ENABLE && (REMOTE_B_TEMP > REMOTE_B_HIGH_LIMIT);
    cond.a_broken = REMOTE_A_ENABLE && REMOTE_A_BROKEN;
    cond.b_broken = REMOTE_B_ENABLE && REMOTE_B_BROKEN;
    // die over-temperature with hysteresis
    if (!ON_CHIP_TEMP_SENSOR_ENABLE) begin
      next_state.die_hot = 1'b0;
    end else if (DIE_TEMP >= DIE_TRIP_CODE) begin
      next_state.die_hot = 1'b1;
    end else if (DIE_TEMP <= DIE_CLEAR_CODE) begin
      next_state.die_hot = 1'b0;
    end
    cond.die = next_state.die_hot;
    // a new condition wins over a clearing read in the same cycle
    for (int i = 0; i < $bits(alarm_bits_s); i++) begin
      next_state.flags[i] = cond[i]
                            || (!FLAG_HOLD_DISABLE && state.flags[i] && !status_read);
    end
    if (!ON_CHIP_TEMP_SENSOR_ENABLE) begin
      next_state.flags.die = 1'b0;
    end
    // only the select register takes writes
    if (REG_WRITE && (REG_ADDRESS == ADDR_CHANNEL_SELECT_ZERO)) begin
      next_state.select = REG_WRITE_DATA[POS_SE0:0];
    end
    next_state.read_valid = REG_READ;
    next_state.read_data = '0;
    if (REG_READ) begin
      case (REG_ADDRESS)
        ADDR_ALARM_STATUS: begin
          next_state.read_data = status_word;
        end
        ADDR_CHANNEL_SELECT_ZERO: begin
          next_state.read_data = select_word;
        end
        default: begin
          next_state.read_data = '0;
        end
      endcase
    end
    // flags set regardless of masks; only the pin is gated
    next_state.alarm_oe_n = !(ALARM_OUTPUT_ENABLE && (|(next_state.flags & ALARM_ENABLE)));
    // open-drain pin only ever pulls low; the enable carries the alarm
    next_state.alarm_out = 1'b0;
    next_state.therm_alarm = next_state.flags.die;
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state <= '0;
      state.select <= CHANNEL_SELECT_RESET[POS_SE0:0];
      state.flags <= ALARM_STATUS_RESET[$bits(alarm_bits_s)-1:0];
      state.alarm_oe_n <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  channel_sequencer u_sequencer (
    .clock        (CLOCK),
    .reset        (RESET),
    .start        (CONV_START),
    .slot_select  (slot_select),
    .busy         (SEQ_BUSY),
    .conv_valid   (CONV_VALID),
    .conv         (CONV_REQUEST),
    .conv_done    (CONV_DONE),
    .conv_code    (CONV_CODE),
    .result_valid (RESULT_VALID),
    .result       (RESULT)
  );

  assign REG_READ_DATA = state.read_data;
  assign REG_READ_VALID = state.read_valid;
  assign ALARM_OUT = state.alarm_out;
  assign ALARM_OE_N = state.alarm_oe_n;
  assign THERM_ALARM = state.therm_alarm;

endmodule
`default_nettype wire

/* File: alarm_flags_sva.sv */
// concurrent checks on the alarm flag and conversion sequencer ports
`timescale 1ns/1ps
`default_nettype none
module alarm_flags_sva (
  // clock and reset
  input wire logic                                      CLOCK,
  input wire logic                                      RESET,
  // register access port
  input wire logic [monitor_pkg::ADDR_WIDTH-1:0]        REG_ADDRESS,
  input wire logic                                      REG_READ,
  input wire logic [monitor_pkg::REG_WIDTH-1:0]         REG_READ_DATA,
  input wire logic                                      REG_READ_VALID,
  // die sensing and alarm pin
  input wire logic signed [monitor_pkg::TEMP_WIDTH-1:0] DIE_TEMP,
  input wire logic                                      ON_CHIP_TEMP_SENSOR_ENABLE,
  input wire logic                                      ALARM_OUTPUT_ENABLE,
  input wire logic                                      ALARM_OE_N,
  input wire logic                                      THERM_ALARM,
  // conversion handshake
  input wire logic                                      CONV_VALID,
  input wire monitor_pkg::conv_req_s                    CONV_REQUEST,
  input wire logic                                      CONV_DONE,
  input wire logic [monitor_pkg::ADC_CODE_WIDTH-1:0]    CONV_CODE,
  input wire logic                                      RESULT_VALID,
  input wire monitor_pkg::result_write_s                RESULT
);
  import monitor_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_die_trip_set: assert property (ON_CHIP_TEMP_SENSOR_ENABLE && DIE_TEMP >= DIE_TRIP_CODE |=> THERM_ALARM)
    else $error("die flag not set at trip point");
  a_die_sensor_off: assert property (!ON_CHIP_TEMP_SENSOR_ENABLE |=> !THERM_ALARM)
    else $error("die flag set with sensor off");
  a_die_hyst_hold: assert property (THERM_ALARM && ON_CHIP_TEMP_SENSOR_ENABLE && DIE_TEMP > DIE_CLEAR_CODE
    && !(REG_READ && REG_ADDRESS == ADDR_ALARM_STATUS) |=> THERM_ALARM)
    else $error("die flag cleared inside hysteresis band");
  a_read_answer: assert property (REG_READ |=> REG_READ_VALID)
    else $error("read not answered next cycle");
  a_sel_reserved: assert property (REG_READ && REG_ADDRESS == ADDR_CHANNEL_SELECT_ZERO |=> !REG_READ_DATA[15])
    else $error("reserved select bit reads one");
  a_req_held: assert property (CONV_VALID && !CONV_DONE |=> CONV_VALID && $stable(CONV_REQUEST))
    else $error("request dropped or changed before done");
  a_result_chan: assert property (CONV_VALID && CONV_DONE |=>
    RESULT_VALID && !CONV_VALID && RESULT.channel == $past(CONV_REQUEST[3:0]))
    else $error("result not written for converted channel");
  a_se_straight: assert property (CONV_VALID && CONV_DONE && !CONV_REQUEST.diff |=>
    RESULT.data == {4'h0, $past(CONV_CODE)})
    else $error("single ended result not zero extended");
  a_diff_signed: assert property (CONV_VALID && CONV_DONE && CONV_REQUEST.diff |=>
    RESULT.data == {{4{$past(CONV_CODE[11])}}, $past(CONV_CODE)})
    else $error("differential result not sign extended");
  a_pin_masked: assert property (!ALARM_OUTPUT_ENABLE |=> ALARM_OE_N)
    else $error("alarm pin driven while output disabled");
endmodule
bind alarm_flags_and_adc_channel_select alarm_flags_sva u_sva (
  .CLOCK                      (CLOCK),
  .RESET                      (RESET),
  .REG_ADDRESS                (REG_ADDRESS),
  .REG_READ                   (REG_READ),
  .REG_READ_DATA              (REG_READ_DATA),
  .REG_READ_VALID             (REG_READ_VALID),
  .DIE_TEMP                   (DIE_TEMP),
  .ON_CHIP_TEMP_SENSOR_ENABLE (ON_CHIP_TEMP_SENSOR_ENABLE),
  .ALARM_OUTPUT_ENABLE        (ALARM_OUTPUT_ENABLE),
  .ALARM_OE_N                 (ALARM_OE_N),
  .THERM_ALARM                (THERM_ALARM),
  .CONV_VALID                 (CONV_VALID),
  .CONV_REQUEST               (CONV_REQUEST),
  .CONV_DONE                  (CONV_DONE),
  .CONV_CODE                  (CONV_CODE),
  .RESULT_VALID               (RESULT_VALID),
  .RESULT                     (RESULT)
);
`default_nettype wire

/* File: converter_model.sv */
// converter model answering each request after a random wait
`timescale 1ns/1ps
`default_nettype none
module converter_model (
  // clock
  input  wire logic        clock,
  // request and answer
  input  wire logic        conv_valid,
  output var  logic        conv_done,
  output var  logic [11:0] conv_code
);
  int wait_cnt = 0;
  initial conv_done = 1'b0;
  initial conv_code = 12'h000;
  always @(negedge clock) begin
    if (conv_done || !conv_valid) begin
      conv_done <= 1'b0;
      // code lines are inverted on each cycle without a request and as the done pulse ends
      conv_code <= ~conv_code;
      wait_cnt  <= $urandom_range(4);
    end else if (wait_cnt == 0) begin
      conv_done <= 1'b1;
      conv_code <= 12'($urandom);
    end else begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_alarm_flags_and_adc_channel_select.sv */
// self-checking bench for the alarm flags and channel select block
`timescale 1ns/1ps
`default_nettype none
module tb_alarm_flags_and_adc_channel_select;
  import monitor_pkg::*;
  logic                    CLOCK, RESET, REG_WRITE, REG_READ, REG_READ_VALID, REMOTE_A_BROKEN, REMOTE_B_BROKEN;
  logic                    REMOTE_A_ENABLE, REMOTE_B_ENABLE, ON_CHIP_TEMP_SENSOR_ENABLE, FLAG_HOLD_DISABLE;
  logic                    ALARM_OUTPUT_ENABLE, ALARM_OUT, ALARM_OE_N, THERM_ALARM, CONV_START, SEQ_BUSY;
  logic                    CONV_VALID, CONV_DONE, RESULT_VALID;
  logic [6:0]              REG_ADDRESS;
  logic [15:0]             REG_WRITE_DATA, REG_READ_DATA, d, e;
  logic signed [11:0]      REMOTE_A_TEMP, REMOTE_A_HIGH_LIMIT, REMOTE_B_TEMP, REMOTE_B_LOW_LIMIT;
  logic signed [11:0]      REMOTE_B_HIGH_LIMIT, DIE_TEMP;
  logic [2:0]              HIGH_CHANNEL_SELECT;
  logic [11:0]             CONV_CODE;
  alarm_bits_s             ALARM_ENABLE;
  conv_req_s               CONV_REQUEST;
  result_write_s           RESULT;
  logic [4:0]              exp_q[$], got_q[$];
  logic                    die_m = 1'b0;
  conv_req_s               last_req;
  logic [11:0]             last_code;
  int                      error_cnt = 0, n_tests = 0, cycles = 0;
  logic signed [11:0]      die_t[7] = '{12'sd1199, 12'sd1200, 12'sd1137, 12'sd1136, 12'sd1199, 12'sd1200, 12'sd1200};
  logic                    die_x[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [15:0]             sel[6] = '{16'h0000, 16'h6000, 16'h1000, 16'h2200, 16'h0c01, 16'hedff};

  alarm_flags_and_adc_channel_select u_dut (.*);
  converter_model u_conv (.clock(CLOCK), .conv_valid(CONV_VALID), .conv_done(CONV_DONE), .conv_code(CONV_CODE));

  always #2 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    if (RESULT_VALID) begin
      check("result chan", 20'(RESULT.channel), 20'(last_req.channel));
      check("result data", 20'(RESULT.data), 20'(last_req.diff ? {{4{last_code[11]}}, last_code} : {4'h0, last_code}));
    end
    if (CONV_VALID && CONV_DONE) begin
      got_q.push_back(CONV_REQUEST);
      last_req = CONV_REQUEST;
      last_code = CONV_CODE;
    end
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    REG_ADDRESS    = a;
    REG_WRITE_DATA = v;
    REG_WRITE      = 1'b1;
    @(negedge CLOCK);
    REG_WRITE = 1'b0;
    @(negedge CLOCK);
  endtask

  task automatic rd(input logic [6:0] a);
    REG_ADDRESS = a;
    REG_READ    = 1'b1;
    @(negedge CLOCK);
    REG_READ = 1'b0;
    d        = REG_READ_DATA;
    @(negedge CLOCK);
  endtask

  function automatic logic [15:0] exp_status();
    logic [15:0] s = 16'h0000;
    s[7] = REMOTE_A_ENABLE && REMOTE_A_TEMP > REMOTE_A_HIGH_LIMIT;
    s[6] = REMOTE_B_ENABLE && REMOTE_B_TEMP < REMOTE_B_LOW_LIMIT;
    s[5] = REMOTE_B_ENABLE && REMOTE_B_TEMP > REMOTE_B_HIGH_LIMIT;
    s[4] = REMOTE_A_ENABLE && REMOTE_A_BROKEN;
    s[3] = REMOTE_B_ENABLE && REMOTE_B_BROKEN;
    s[2] = die_m;
    return s;
  endfunction

  // keep each channel pair to a documented select combination
  function automatic logic [15:0] legal_sel(input logic [15:0] s);
    logic [15:0] r;
    r = s;
    if (r[14] || r[13]) r[12] = 1'b0;
    if (r[11] || r[10]) r[9] = 1'b0;
    return r;
  endfunction

  function automatic void expect_slots(input logic [15:0] s, input logic [2:0] h);
    exp_q.delete();
    if (s[14]) exp_q.push_back(5'h00);
    if (s[13]) exp_q.push_back(5'h01);
    if (s[12] && !s[14] && !s[13]) exp_q.push_back(5'h10);
    if (s[11]) exp_q.push_back(5'h02);
    if (s[10]) exp_q.push_back(5'h03);
    if (s[9] && !s[11] && !s[10]) exp_q.push_back(5'h12);
    for (int i = 8; i >= 0; i--) if (s[i]) exp_q.push_back(5'(12 - i));
    for (int i = 2; i >= 0; i--) if (h[i]) exp_q.push_back(5'(15 - i));
  endfunction

  task automatic run_pass(input logic [15:0] s, input logic [2:0] h);
    int i = 0;
    wr(ADDR_CHANNEL_SELECT_ZERO, s);
    HIGH_CHANNEL_SELECT = h;
    expect_slots(s, h);
    got_q.delete();
    CONV_START = 1'b1;
    @(negedge CLOCK);
    CONV_START = 1'b0;
    check("busy", 20'(SEQ_BUSY), 20'(exp_q.size() != 0));
    while (SEQ_BUSY !== 1'b0 && i < 400) begin
      @(negedge CLOCK);
      i++;
    end
    check("slot count", 20'(got_q.size()), 20'(exp_q.size()));
    foreach (exp_q[k]) check("slot", 20'(got_q[k]), 20'(exp_q[k]));
  endtask

  initial begin
    {CLOCK, REG_WRITE, REG_READ, CONV_START, REG_ADDRESS, REG_WRITE_DATA, HIGH_CHANNEL_SELECT} = '0;
    {REMOTE_A_TEMP, REMOTE_A_HIGH_LIMIT, REMOTE_B_TEMP, REMOTE_B_LOW_LIMIT, REMOTE_B_HIGH_LIMIT, DIE_TEMP} = '0;
    {REMOTE_A_BROKEN, REMOTE_B_BROKEN, REMOTE_A_ENABLE, REMOTE_B_ENABLE, ALARM_ENABLE} = '0;
    {ON_CHIP_TEMP_SENSOR_ENABLE, FLAG_HOLD_DISABLE, ALARM_OUTPUT_ENABLE} = 3'b011;
    RESET = 1'b1;
    void'($urandom(94310));
    repeat (16) @(negedge CLOCK);
    RESET = 1'b0;
    rd(ADDR_ALARM_STATUS);
    check("status reset", 20'(d), 20'(ALARM_STATUS_RESET));
    rd(ADDR_CHANNEL_SELECT_ZERO);
    check("select reset", 20'(d), 20'(CHANNEL_SELECT_RESET));
    wr(ADDR_CHANNEL_SELECT_ZERO, 16'hedff);
    rd(ADDR_CHANNEL_SELECT_ZERO);
    check("select rw", 20'(d), 20'h06dff);
    wr(ADDR_CHANNEL_SELECT_ZERO, 16'h9200);
    rd(ADDR_CHANNEL_SELECT_ZERO);
    check("select diff rw", 20'(d), 20'h01200);
    rd(7'h10);
    check("unmapped", 20'(d), 20'h00000);
    repeat (40) begin
      {REMOTE_A_ENABLE, REMOTE_B_ENABLE, REMOTE_A_BROKEN, REMOTE_B_BROKEN, ALARM_OUTPUT_ENABLE} = 5'($urandom);
      {REMOTE_A_TEMP, REMOTE_A_HIGH_LIMIT, REMOTE_B_TEMP} = 36'({$urandom, $urandom});
      {REMOTE_B_LOW_LIMIT, REMOTE_B_HIGH_LIMIT} = 24'($urandom);
      ALARM_ENABLE = alarm_bits_s'(6'($urandom));
      // die readings around the trip and clear points
      ON_CHIP_TEMP_SENSOR_ENABLE = 1'($urandom);
      DIE_TEMP = 12'(1100 + $urandom_range(140));
      if (!ON_CHIP_TEMP_SENSOR_ENABLE) die_m = 1'b0;
      else if (DIE_TEMP >= DIE_TRIP_CODE) die_m = 1'b1;
      else if (DIE_TEMP <= DIE_CLEAR_CODE) die_m = 1'b0;
      wr(ADDR_ALARM_STATUS, 16'hffff);
      rd(ADDR_ALARM_STATUS);
      e = exp_status();
      check("status", 20'(d), 20'(e));
      check("pin", 20'(ALARM_OE_N), 20'(!(ALARM_OUTPUT_ENABLE && |(ALARM_ENABLE & e[7:2]))));
      check("therm", 20'(THERM_ALARM), 20'(die_m));
      check("pin data", 20'(ALARM_OUT), 20'h00000);
    end
    ON_CHIP_TEMP_SENSOR_ENABLE = 1'b0;
    @(negedge CLOCK);
    foreach (die_t[k]) begin
      DIE_TEMP = die_t[k];
      ON_CHIP_TEMP_SENSOR_ENABLE = (k != 6);
      @(negedge CLOCK);
      check("die", 20'(THERM_ALARM), 20'(die_x[k]));
    end
    {REMOTE_A_ENABLE, REMOTE_B_ENABLE, ALARM_OUTPUT_ENABLE} = 3'b101;
    ALARM_ENABLE = alarm_bits_s'(6'h20);
    {REMOTE_A_BROKEN, REMOTE_A_HIGH_LIMIT, REMOTE_A_TEMP} = {1'b0, 12'sd256, 12'sd512};
    @(negedge CLOCK);
    FLAG_HOLD_DISABLE = 1'b0;
    rd(ADDR_ALARM_STATUS);
    check("held high", 20'(d), 20'h00080);
    REMOTE_A_TEMP = 12'sd0;
    @(negedge CLOCK);
    check("held pin", 20'(ALARM_OE_N), 20'h00000);
    rd(ADDR_ALARM_STATUS);
    check("held gone", 20'(d), 20'h00080);
    rd(ADDR_ALARM_STATUS);
    check("cleared", 20'(d), 20'h00000);
    foreach (sel[k]) run_pass(sel[k], (k == 0) ? 3'b000 : 3'($urandom));
    repeat (10) run_pass(legal_sel(16'($urandom)), 3'($urandom));
    results();
  end
endmodule
`default_nettype wire
